// *** logic/eic_frame_rx.sv ***
// Purpose: Assembles nine-byte command frames and checks the checksum
// Assumes: Bytes come from logic on the same clock, one per valid cycle
// Notes:   Frames for another target address are dropped silently
`timescale 1ns/1ns
`default_nettype none
module eic_frame_rx #(
    parameter logic [7:0] MY_ADDR = 8'h01
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // Byte stream
    input  wire logic [7:0]        rx_byte,
    input  wire logic              rx_valid,
    // Decoded frame
    output logic                   frm_valid,
    output logic                   frm_sum_ok,
    output eic_pkg::eic_cmd_t      frm_cmd
);
    import eic_pkg::*;

    logic [3:0]  idx_reg;
    logic [7:0]  sum_reg;
    logic [7:0]  addr_reg;
    logic [63:0] body_reg;
    wire         last_byte = rx_valid && (idx_reg == FRAME_LAST);
    wire  [7:0]  sum_next  = sum_reg + rx_byte;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            idx_reg    <= 4'h0;
            sum_reg    <= 8'h00;
            addr_reg   <= 8'h00;
            body_reg   <= 64'h0;
            frm_valid  <= 1'b0;
            frm_sum_ok <= 1'b0;
            frm_cmd    <= '0;
        end else begin
            frm_valid <= last_byte && (addr_reg == MY_ADDR); // R19
            if (rx_valid) begin
                idx_reg <= last_byte ? 4'h0 : idx_reg + 4'h1;
                sum_reg <= last_byte ? 8'h00 : sum_next;
                if (idx_reg == 4'h0) begin
                    addr_reg <= rx_byte;
                end else if (!last_byte) begin
                    body_reg <= {body_reg[55:0], rx_byte}; // R19
                end
            end
            if (last_byte) begin
                frm_sum_ok <= (rx_byte == sum_reg); // R20
                frm_cmd    <= body_reg[55:0];
            end
        end
    end
endmodule : eic_frame_rx
`default_nettype wire

// *** logic/eic_pkg.sv ***
// Purpose: Shared constants and types for the error flag and interrupt control block
// Assumes: One clock, synchronous active-low reset
// Notes:   Instruction codes, flag positions, bus offsets and reply codes
package eic_pkg;

    // Instruction codes
    localparam logic [7:0] INS_FLAG_CLEAR = 8'h24;
    localparam logic [7:0] INS_UNMASK     = 8'h19;
    localparam logic [7:0] INS_BLOCK      = 8'h1A;
    localparam logic [7:0] INS_ENTRY_SET  = 8'h25;
    localparam logic [7:0] INS_RETURN     = 8'h26;
    localparam logic [7:0] NUM_GLOBAL     = 8'hFF;

    // Flag-clear type codes
    localparam logic [7:0] CLR_ALL        = 8'h00;
    localparam logic [7:0] CLR_LAST       = 8'h05;

    // Error flag bit positions
    localparam int FLAG_W                 = 5;
    localparam int FLG_TIMEOUT            = 0;
    localparam int FLG_ALARM              = 1;
    localparam int FLG_DEVIATION          = 2;
    localparam int FLG_POSITION           = 3;
    localparam int FLG_SHUTDOWN           = 4;

    // Frame layout
    localparam logic [3:0] FRAME_LAST     = 4'h8;
    localparam logic [7:0] ST_OK          = 8'h64;
    localparam logic [7:0] ST_BAD_SUM     = 8'h01;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_ERR_FLAGS  = 8'h04;
    localparam logic [7:0] OFS_IRQ_EN     = 8'h08;
    localparam logic [7:0] OFS_STATUS     = 8'h0C;
    localparam logic [7:0] OFS_SAVED_PC   = 8'h10;
    localparam int         STAT_IDX_POS   = 8;
    localparam int         STAT_PEND_POS  = 16;

    // Reset values
    localparam logic       RST_GLOBAL_EN  = 1'b0;
    localparam logic [31:0] RST_WORD      = 32'h0000_0000;

    typedef struct packed {
        logic [7:0]  instr;
        logic [7:0]  kind;
        logic [7:0]  bank;
        logic [31:0] value;
    } eic_cmd_t;

    typedef struct packed {
        logic [31:0] acc;
        logic [31:0] xreg;
        logic [7:0]  flags;
        logic [31:0] pc;
    } eic_ctx_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_FETCH   = 2'b01,
        ST_HANDLER = 2'b10
    } eic_state_t;

endpackage : eic_pkg

// *** logic/eic_top.sv ***
// Purpose: Error flag clearing and interrupt control for a command interpreter
// Assumes: Frame bytes and CPU context on this clock; events and sources are pins
// Notes:   Registers over APB with one wait state; no nested handlers
//
// Overview of operation
// R1: Instruction 36 clears error flags chosen by type; bank and value ignored.
// R2: Type 0 clears every error flag at once.
// R3: Type 1 clears only the timeout flag.
// R4: Type 2 clears only the external alarm flag.
// R5: Type 3 clears only the deviation flag.
// R6: Type 4 clears only the position error flag.
// R7: Type 5 clears only the shutdown flag.
// R8: Instruction 25 enables the interrupt numbered by type.
// R9: Enable with number 255 turns global interrupt processing on.
// R10: Instruction 26 disables the interrupt numbered by type.
// R11: Disable with number 255 turns global interrupt processing off.
// R12: Instruction 37 stores value as handler entry for the numbered interrupt.
// R13: Program supplies the handler's first instruction address as vector.
// R14: A later vector for the same number replaces the stored one.
// R15: Instruction 38 ends the handler and resumes the interrupted program.
// R16: Return restores accumulator, X register, flags and program counter.
// R17: Every handler in the program ends with the return instruction.
// R18: Program flow never falls through into a handler body.
// R19: Frame is address, instruction, type, bank, value msb first, checksum.
// R20: Checksum is modulo-256 sum of eight bytes; success reply status 100.
// R21: Entry saves context and jumps to vector only if both enables set.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module eic_top #(
    parameter int         N_IRQ   = 8,
    parameter int         IW      = 3,
    parameter logic [7:0] MY_ADDR = 8'h01
) (
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               rst_n,
    // APB slave
    input  wire logic [7:0]         paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    // Command frame bytes
    input  wire logic [7:0]         rx_byte,
    input  wire logic               rx_valid,
    // Reply
    output logic                    reply_valid,
    output logic [7:0]              reply_status,
    output logic [7:0]              reply_instr,
    // Error events and interrupt sources, asynchronous
    input  wire logic [4:0]         err_event,
    input  wire logic [N_IRQ-1:0]   irq_src,
    // CPU context
    input  wire eic_pkg::eic_ctx_t  cpu_ctx,
    output logic                    jump_valid,
    output logic [31:0]             jump_pc,
    output logic                    restore_valid,
    output eic_pkg::eic_ctx_t       restore_ctx
);
    import eic_pkg::*;

    // Flag-clear type to flag mask
    function automatic logic [FLAG_W-1:0] clr_mask(input logic [7:0] kind);
        logic [FLAG_W-1:0] m;
        m = '0;
        if (kind == CLR_ALL) begin
            m = '1;
        end else if (kind <= CLR_LAST) begin
            m[kind[2:0] - 3'h1] = 1'b1;
        end
        return m;
    endfunction : clr_mask

    // Lowest-numbered set bit wins
    function automatic logic [IW-1:0] first_set(input logic [N_IRQ-1:0] v);
        logic [IW-1:0] n;
        n = '0;
        for (int i = N_IRQ - 1; i >= 0; i--) begin
            if (v[i]) begin
                n = IW'(i);
            end
        end
        return n;
    endfunction : first_set

    // Frame receiver
    logic      frm_valid;
    logic      frm_sum_ok;
    eic_cmd_t  cmd;

    eic_frame_rx #(
        .MY_ADDR (MY_ADDR)
    ) u_rx (
        .clock      (clock),
        .rst_n      (rst_n),
        .rx_byte    (rx_byte),
        .rx_valid   (rx_valid),
        .frm_valid  (frm_valid),
        .frm_sum_ok (frm_sum_ok),
        .frm_cmd    (cmd)
    );

    // Pin synchronisers; third irq stage for edge detect
    logic [4:0]       err_s1_reg;
    logic [4:0]       err_s2_reg;
    logic [N_IRQ-1:0] irq_s1_reg;
    logic [N_IRQ-1:0] irq_s2_reg;
    logic [N_IRQ-1:0] irq_s3_reg;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            err_s1_reg <= '0;
            err_s2_reg <= '0;
            irq_s1_reg <= '0;
            irq_s2_reg <= '0;
            irq_s3_reg <= '0;
        end else begin
            err_s1_reg <= err_event;
            err_s2_reg <= err_s1_reg;
            irq_s1_reg <= irq_src;
            irq_s2_reg <= irq_s1_reg;
            irq_s3_reg <= irq_s2_reg;
        end
    end

    // Command decode
    wire       cmd_ok     = frm_valid && frm_sum_ok;
    wire       is_clear   = cmd_ok && (cmd.instr == INS_FLAG_CLEAR);
    wire       is_unmask  = cmd_ok && (cmd.instr == INS_UNMASK);
    wire       is_block   = cmd_ok && (cmd.instr == INS_BLOCK);
    wire       is_entry   = cmd_ok && (cmd.instr == INS_ENTRY_SET);
    wire       is_return  = cmd_ok && (cmd.instr == INS_RETURN);
    wire       is_mine    = is_clear || is_unmask || is_block || is_entry || is_return;
    wire       num_global = (cmd.kind == NUM_GLOBAL);
    wire       num_in     = (cmd.kind < 8'(N_IRQ));
    wire [IW-1:0]    num_idx = cmd.kind[IW-1:0];
    wire [N_IRQ-1:0] num_bit = num_in ? (N_IRQ'(1) << num_idx) : '0;

    // APB decode; writes land on the edge that completes the access
    logic             pready_reg;
    wire              apb_access = psel && penable && !pready;
    wire              apb_done   = psel && penable && pready;
    wire              apb_wr     = apb_done && pwrite;
    wire              wr_ctrl    = apb_wr && (paddr == OFS_CTRL);
    wire              wr_err     = apb_wr && (paddr == OFS_ERR_FLAGS);
    wire              wr_en      = apb_wr && (paddr == OFS_IRQ_EN);

    // Error flags: pins set, command or bus clears; set wins
    logic [FLAG_W-1:0] err_flags_reg;
    wire  [FLAG_W-1:0] cmd_clr  = is_clear ? clr_mask(cmd.kind) : '0; // R1 R2 R3 R4 R5 R6 R7
    wire  [FLAG_W-1:0] bus_clr  = wr_err ? pwdata[FLAG_W-1:0] : '0;
    wire  [FLAG_W-1:0] err_next = (err_flags_reg & ~(cmd_clr | bus_clr)) | err_s2_reg;

    // Enables: command wins over a bus write in the same cycle
    logic             global_en_reg;
    logic [N_IRQ-1:0] irq_en_reg;
    wire              glob_base  = wr_ctrl ? pwdata[0] : global_en_reg;
    wire              global_next = (is_unmask && num_global) ? 1'b1 :   // R9
                                    (is_block && num_global) ? 1'b0 :    // R11
                                    glob_base;
    wire [N_IRQ-1:0]  en_base    = wr_en ? pwdata[N_IRQ-1:0] : irq_en_reg;
    wire [N_IRQ-1:0]  en_set     = is_unmask ? num_bit : '0;             // R8
    wire [N_IRQ-1:0]  en_clr     = is_block ? num_bit : '0;              // R10
    wire [N_IRQ-1:0]  en_next    = (en_base | en_set) & ~en_clr;

    // Pending sources, rising edge sets; entry clears the taken one
    eic_state_t       state_reg;
    logic [N_IRQ-1:0] pend_reg;
    logic [IW-1:0]    active_reg;
    eic_ctx_t         saved_reg;
    wire [N_IRQ-1:0]  src_rise  = irq_s2_reg & ~irq_s3_reg;
    wire [N_IRQ-1:0]  eligible  = global_en_reg ? (pend_reg & irq_en_reg) : '0; // R21
    wire              take_irq  = (state_reg == ST_IDLE) && (eligible != '0);
    wire [IW-1:0]     take_idx  = first_set(eligible);
    wire [N_IRQ-1:0]  take_bit  = take_irq ? (N_IRQ'(1) << take_idx) : '0;
    wire [N_IRQ-1:0]  pend_next = (pend_reg & ~take_bit) | src_rise;
    wire              leave     = (state_reg == ST_HANDLER) && is_return;

    // Entry addresses; a redefinition simply overwrites the word
    logic [31:0]      vec_rd;

    eic_vec_mem #(
        .AW (IW),
        .DW (32)
    ) u_vec (
        .clock   (clock),
        .wr_en   (is_entry && num_in),        // R12 R14
        .wr_addr (num_idx),
        .wr_data (cmd.value),                 // R13
        .rd_addr (take_idx),
        .rd_data (vec_rd)
    );

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            err_flags_reg <= '0;
            global_en_reg <= RST_GLOBAL_EN;
            irq_en_reg    <= '0;
            pend_reg      <= '0;
        end else begin
            err_flags_reg <= err_next;
            global_en_reg <= global_next;
            irq_en_reg    <= en_next;
            pend_reg      <= pend_next;
        end
    end

    // Entry and return sequence
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg     <= ST_IDLE;
            active_reg    <= '0;
            saved_reg     <= '0;
            jump_valid    <= 1'b0;
            jump_pc       <= RST_WORD;
            restore_valid <= 1'b0;
            restore_ctx   <= '0;
        end else begin
            jump_valid    <= 1'b0;
            restore_valid <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (take_irq) begin
                        saved_reg  <= cpu_ctx;              // R21
                        active_reg <= take_idx;
                        state_reg  <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    jump_valid <= 1'b1;                     // R21
                    jump_pc    <= vec_rd;
                    state_reg  <= ST_HANDLER;
                end
                ST_HANDLER: begin
                    if (leave) begin
                        restore_valid <= 1'b1;              // R15
                        restore_ctx   <= saved_reg;         // R16
                        state_reg     <= ST_IDLE;           // R17
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Reply for frames this block owns or that fail the checksum
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reply_valid  <= 1'b0;
            reply_status <= 8'h00;
            reply_instr  <= 8'h00;
        end else begin
            reply_valid <= is_mine || (frm_valid && !frm_sum_ok);
            if (frm_valid) begin
                reply_status <= frm_sum_ok ? ST_OK : ST_BAD_SUM;  // R20
                reply_instr  <= cmd.instr;
            end
        end
    end

    // Register read mux
    wire        sel_ctrl  = (paddr == OFS_CTRL);
    wire        sel_err   = (paddr == OFS_ERR_FLAGS);
    wire        sel_en    = (paddr == OFS_IRQ_EN);
    wire        sel_stat  = (paddr == OFS_STATUS);
    wire        sel_pc    = (paddr == OFS_SAVED_PC);
    wire        mapped    = sel_ctrl || sel_err || sel_en || sel_stat || sel_pc;
    wire [31:0] stat_word = (32'(state_reg))
                          | (32'(active_reg) << STAT_IDX_POS)
                          | (32'(pend_reg) << STAT_PEND_POS);
    wire [31:0] rd_word   = sel_ctrl ? 32'(global_en_reg) :
                            sel_err  ? 32'(err_flags_reg) :
                            sel_en   ? 32'(irq_en_reg)    :
                            sel_stat ? stat_word          :
                            sel_pc   ? saved_reg.pc       : RST_WORD;

    // One wait state: answer registered in the first access cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pready_reg <= 1'b0;
            prdata     <= RST_WORD;
            pslverr    <= 1'b0;
        end else begin
            pready_reg <= apb_access;
            if (apb_access) begin
                prdata  <= pwrite ? RST_WORD : rd_word;
                pslverr <= !mapped;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    assign pready = pready_reg;

endmodule : eic_top
`default_nettype wire

// *** logic/eic_vec_mem.sv ***
// Purpose: Handler entry address store, one word per interrupt number
// Assumes: Read data registered, one cycle after the address
// Notes:   Read of a word being written returns the old word
`timescale 1ns/1ns
`default_nettype none
module eic_vec_mem #(
    parameter int AW = 3,
    parameter int DW = 32
) (
    // Clock
    input  wire logic          clock,
    // Write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    // Read port
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock) begin
        rd_data <= mem[rd_addr];
    end
endmodule : eic_vec_mem
`default_nettype wire

// *** verif/eic_host_model.sv ***
// Purpose: Command source that sends whole frames to the block
// Assumes: Caller enters send just after a rising edge
// Notes:   A bad checksum is the inverted sum, never a match
`timescale 1ns/1ns
`default_nettype none
module eic_host_model #(
    parameter logic [7:0] MY_ADDR = 8'h01
) (
    // Clock
    input  wire logic       clock,
    // Frame byte stream
    output var  logic [7:0] rx_byte,
    output var  logic       rx_valid
);
    initial begin
        rx_byte  = 8'h00;
        rx_valid = 1'b0;
    end

    task automatic send(input logic [7:0] ins, input logic [7:0] kind,
                        input logic [31:0] val, input logic good);
        logic [7:0] b [9];
        logic [7:0] sum;
        b = '{MY_ADDR, ins, kind, 8'h00, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
        sum = 8'h00;
        for (int i = 0; i < 8; i++) sum += b[i];
        b[8] = good ? sum : ~sum;
        for (int i = 0; i < 9; i++) begin
            @(posedge clock);
            rx_byte  <= b[i];
            rx_valid <= 1'b1;
        end
        @(posedge clock);
        rx_valid <= 1'b0;
        rx_byte  <= ~b[8]; // Released line must not hold a stale byte
    endtask : send
endmodule : eic_host_model
`default_nettype wire

// *** verif/eic_monitor.sv ***
// Purpose: Port-level checks for the error flag and interrupt block
// Assumes: Nine-byte frames, counter cleared by reset and after each ninth byte
// Notes:   Frame helper mirrors the byte count so replies can be tied to frames
`timescale 1ns/1ns
`default_nettype none
module eic_monitor
    import eic_pkg::*;
#(
    parameter int         N_IRQ   = 8,
    parameter int         IW      = 3,
    parameter logic [7:0] MY_ADDR = 8'h01
) (
    // Clock and reset
    input wire logic              clock,
    input wire logic              rst_n,
    // APB
    input wire logic [7:0]        paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    // Frames and reply
    input wire logic [7:0]        rx_byte,
    input wire logic              rx_valid,
    input wire logic              reply_valid,
    input wire logic [7:0]        reply_status,
    input wire logic [7:0]        reply_instr,
    // Events and context
    input wire logic [4:0]        err_event,
    input wire logic [N_IRQ-1:0]  irq_src,
    input wire eic_pkg::eic_ctx_t cpu_ctx,
    input wire logic              jump_valid,
    input wire logic [31:0]       jump_pc,
    input wire logic              restore_valid,
    input wire eic_pkg::eic_ctx_t restore_ctx
);
    logic [3:0] cnt_reg;
    logic [7:0] sum_reg;
    logic [7:0] adr_reg;
    logic [7:0] ins_reg;
    logic       due1_reg;
    logic       due2_reg;
    logic       hnd_reg;
    wire        fin   = rx_valid && (cnt_reg == 4'h8);
    wire        known = ins_reg inside {INS_FLAG_CLEAR, INS_UNMASK, INS_BLOCK,
                                        INS_ENTRY_SET, INS_RETURN};
    wire        take  = fin && (adr_reg == MY_ADDR) && (known || sum_reg != rx_byte);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_reg  <= 4'h0;
            sum_reg  <= 8'h00;
            adr_reg  <= 8'h00;
            ins_reg  <= 8'h00;
            due1_reg <= 1'b0;
            due2_reg <= 1'b0;
            hnd_reg  <= 1'b0;
        end else begin
            cnt_reg  <= rx_valid ? (fin ? 4'h0 : cnt_reg + 4'h1) : cnt_reg;
            sum_reg  <= rx_valid ? (fin ? 8'h00 : sum_reg + rx_byte) : sum_reg;
            adr_reg  <= (rx_valid && cnt_reg == 4'h0) ? rx_byte : adr_reg;
            ins_reg  <= (rx_valid && cnt_reg == 4'h1) ? rx_byte : ins_reg;
            due1_reg <= take;
            due2_reg <= due1_reg;
            hnd_reg  <= jump_valid ? 1'b1 : (restore_valid ? 1'b0 : hnd_reg);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_reply_on_time: assert property (take |-> ##2 reply_valid)
        else $error("reply missing two cycles after frame");
    a_reply_ok_code: assert property ((take && sum_reg == rx_byte) |-> ##2
        (reply_status == ST_OK && reply_instr == ins_reg)) else $error("bad ok reply");
    a_reply_bad_sum: assert property ((take && sum_reg != rx_byte) |-> ##2
        (reply_valid && reply_status == ST_BAD_SUM)) else $error("bad checksum not reported");
    a_reply_has_cause: assert property (reply_valid |-> due2_reg)
        else $error("reply without a frame");
    a_restore_by_return: assert property (restore_valid |->
        (reply_valid && reply_instr == INS_RETURN)) else $error("restore without return");
    a_restore_in_handler: assert property (restore_valid |-> hnd_reg)
        else $error("restore outside handler");
    a_no_nested_entry: assert property (hnd_reg |-> !jump_valid)
        else $error("entry while in handler");
    a_jump_one_cycle: assert property (jump_valid |=> !jump_valid)
        else $error("jump pulse too long");
    a_ready_timing: assert property ((psel && !penable) |-> ##2 pready)
        else $error("pready not on second edge");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_slverr_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
endmodule : eic_monitor

bind eic_top eic_monitor #(.N_IRQ(N_IRQ), .IW(IW), .MY_ADDR(MY_ADDR)) eic_monitor_inst (
    .clock, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr,
    .rx_byte, .rx_valid, .reply_valid, .reply_status, .reply_instr, .err_event, .irq_src,
    .cpu_ctx, .jump_valid, .jump_pc, .restore_valid, .restore_ctx
);
`default_nettype wire

// *** verif/eic_top_tb.sv ***
// Purpose: Self-checking bench for the error flag and interrupt block
// Assumes: APB answers on its own time; frames come from the host model
// Notes:   Register reads stand in for internal flags and enables
`timescale 1ns/1ns
`default_nettype none
module eic_top_tb;
    import eic_pkg::*;
    logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, er, rv;
    logic        rx_valid, reply_valid, jump_valid, restore_valid, seen;
    logic [7:0]  paddr, rx_byte, reply_status, reply_instr, irq_src;
    logic [31:0] pwdata, prdata, jump_pc, rd, exp;
    logic [4:0]  err_event;
    eic_ctx_t    cpu_ctx, restore_ctx, rc, ctx_e;
    int          fails, check_count, n;

    eic_top #(.N_IRQ(8), .IW(3), .MY_ADDR(8'h01)) eic_top_inst (
        .clock, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr,
        .rx_byte, .rx_valid, .reply_valid, .reply_status, .reply_instr, .err_event, .irq_src,
        .cpu_ctx, .jump_valid, .jump_pc, .restore_valid, .restore_ctx);
    eic_host_model #(.MY_ADDR(8'h01)) eic_host_model_inst (.clock, .rx_byte, .rx_valid);

    task automatic chk(input logic [127:0] got, input logic [127:0] want);
        check_count++;
        if (got !== want) begin
            fails++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, got, want);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 16) fails++;
    endtask : apb

    task automatic frame(input logic [7:0] ins, input logic [7:0] kind,
                         input logic [31:0] val, input logic good);
        int k;
        eic_host_model_inst.send(ins, kind, val, good);
        k = 0;
        while (reply_valid !== 1'b1 && k < 8) begin
            @(posedge clock);
            k++;
        end
        rv = restore_valid;
        rc = restore_ctx;
        chk(reply_valid, 1'b1);
        chk(reply_status, good ? ST_OK : ST_BAD_SUM);
        chk(reply_instr, ins);
    endtask : frame

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        complete_run();
    end

    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, err_event, irq_src} = '0;
        cpu_ctx = '0;
        ctx_e = '{acc: 32'hA5A5_0001, xreg: 32'h5A5A_0002, flags: 8'h3C, pc: 32'h0000_0777};
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        for (int a = 0; a < 5; a++) begin
            apb(1'b0, 8'(a * 4), 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b0, 8'h40, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h0);
        for (int t = 0; t <= 6; t++) begin
            err_event <= 5'h1F;
            repeat (6) @(posedge clock);
            err_event <= 5'h00;
            repeat (6) @(posedge clock);
            frame(INS_FLAG_CLEAR, 8'(t % 6), 32'hFFFF_FFFF, t != 6);
            apb(1'b0, OFS_ERR_FLAGS, 32'h0);
            exp = (t == 0) ? 32'h0 : (t == 6) ? 32'h1F : 32'h1F & ~(32'h1 << (t - 1));
            chk(rd, exp);
        end
        apb(1'b1, OFS_ERR_FLAGS, 32'h3);
        apb(1'b0, OFS_ERR_FLAGS, 32'h0);
        chk(rd, 32'h1C);
        frame(INS_ENTRY_SET, 8'h02, 32'h0000_0050, 1'b1);
        frame(INS_ENTRY_SET, 8'h02, 32'h0000_1234, 1'b1);
        frame(INS_UNMASK, 8'h02, 32'hDEAD_0000, 1'b1);
        frame(INS_UNMASK, NUM_GLOBAL, 32'h0, 1'b1);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, OFS_IRQ_EN, 32'h0);
        chk(rd, 32'h4);
        cpu_ctx <= ctx_e;
        irq_src <= 8'h04;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (jump_valid !== 1'b1 && n < 24);
        chk(jump_pc, 32'h0000_1234);
        apb(1'b0, OFS_SAVED_PC, 32'h0);
        chk(rd, 32'h0000_0777);
        @(posedge clock);
        cpu_ctx <= ~ctx_e;
        frame(INS_RETURN, NUM_GLOBAL, 32'h0, 1'b1);
        chk(rv, 1'b1);
        chk(rc, ctx_e);
        frame(INS_BLOCK, 8'h02, 32'h0, 1'b1);
        frame(INS_BLOCK, NUM_GLOBAL, 32'h0, 1'b1);
        apb(1'b0, OFS_IRQ_EN, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        irq_src <= 8'h00;
        repeat (4) @(posedge clock);
        irq_src <= 8'h04;
        seen = 1'b0;
        repeat (16) begin
            @(posedge clock);
            seen = seen | (jump_valid === 1'b1);
        end
        chk(seen, 1'b0);
        complete_run();
    end
endmodule : eic_top_tb
`default_nettype wire
